// ### rtl/psc_pkg.sv
package psc_pkg;
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned BE_W = 2;
   // timing figures as printed
   localparam int unsigned READ_CYCLE_TIME_NS = 70;
   localparam int unsigned WRITE_PULSE_NS = 50;
   localparam int unsigned WRITE_CYCLE_NS = 70;
   localparam int unsigned DATA_OVERLAP_NS = 30;
   localparam int unsigned WRITE_TO_FLOAT_NS = 20;
   localparam int unsigned EXIT_WAIT_US = 200;
   // least times round up
   localparam int unsigned RC_CYC = (READ_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned WP_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned WC_CYC = (WRITE_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned FLOAT_CYC = (WRITE_TO_FLOAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // strictly more than the exit wait
   localparam int unsigned EXIT_CYC = (EXIT_WAIT_US * 1000000) / CLK_PERIOD_PS + 1;
   localparam int unsigned CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [BE_W-1:0] byte_en;
   } psc_req_s;

   typedef struct packed {
      logic chip_select_n;
      logic write_strobe_n;
      logic output_enable_n;
      logic upper_byte_enable_n;
      logic low_byte_enable_n;
      logic power_keep_select;
   } psc_ctl_s;

   localparam psc_ctl_s CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : psc_pkg

// ### rtl/psc_ctrl.sv
// How it works
// R01: a write happens only while chip select, write strobe and a byte enable are all low.
// R02: the write ends when chip select or write strobe rises, whichever is first.
// R03: with select and byte enables falling with or after the strobe the memory keeps its bus off.
// R04: with output enable held low through a write the memory drives data for the next address.
// R05: chip select high means standby and low means active; this end picks the mode.
// R06: this end never drives the data pins while the memory may drive them.
// R07: the address stays fixed while chip select and write strobe are both low.
// R08: short-address read bursts over the refresh window must be followed by normal reads.
// R09: alternatively chip select goes high for at least one read cycle time.
// R10: a read has write strobe high, output enable, a byte enable and select low, and keep high.
// R11: power keep low puts the memory in deep power-down for as long as it stays low.
// R12: after leaving deep power-down this end waits over the exit time before any access.
// R13: the upper enable gates bits 15 to 8 and the lower enable bits 7 to 0.
// R14: every read cycle and write pulse is counted out to its least length in clocks.
`timescale 1ns/1ps
`default_nettype none
module psc_ctrl #(
   parameter int unsigned EXIT_WAIT = psc_pkg::EXIT_CYC
) (
   input wire logic i_clock, // 125 MHz
   input wire logic i_nrst, // sync, active low
   input wire logic i_req_valid, // request offered
   input var psc_pkg::psc_req_s i_req, // request payload
   output logic o_req_ready, // request taken this cycle
   input wire logic i_power_down, // ask for deep power-down
   output logic o_rdata_valid, // read data pulse
   output logic [psc_pkg::DATA_W-1:0] o_rdata, // read data
   output logic o_busy, // power-down, power-up wait or cycle in flight
   output logic [psc_pkg::ADDR_W-1:0] o_addr, // memory address pins
   output var psc_pkg::psc_ctl_s o_ctl, // memory control pins
   input wire logic [psc_pkg::DATA_W-1:0] i_dq, // data pins in
   output logic [psc_pkg::DATA_W-1:0] o_dq, // data pins out
   output logic [psc_pkg::DATA_W-1:0] o_dq_oe // data pins enable per bit
);
   typedef enum logic [2:0] {
      ST_WAKE, ST_IDLE, ST_READ, ST_WSETUP, ST_WPULSE, ST_WREC, ST_SLEEP
   } psc_state_e;

   localparam logic [psc_pkg::CNT_W-1:0] RC_N = psc_pkg::CNT_W'(psc_pkg::RC_CYC);
   localparam logic [psc_pkg::CNT_W-1:0] WP_N = psc_pkg::CNT_W'(psc_pkg::WP_CYC);
   localparam logic [psc_pkg::CNT_W-1:0] FL_N = psc_pkg::CNT_W'(psc_pkg::FLOAT_CYC);
   localparam logic [psc_pkg::CNT_W-1:0] REC_N =
      psc_pkg::CNT_W'(psc_pkg::WC_CYC - psc_pkg::WP_CYC);
   localparam logic [psc_pkg::CNT_W-1:0] EX_N = psc_pkg::CNT_W'(EXIT_WAIT);

   localparam int unsigned LANE_W = psc_pkg::DATA_W / psc_pkg::BE_W;

   // pins are active low, request enables active high
   function automatic logic [psc_pkg::BE_W-1:0] lanes_n(input logic [psc_pkg::BE_W-1:0] be);
      lanes_n = ~be;
   endfunction : lanes_n

   psc_state_e state;
   psc_state_e next_state;
   logic [psc_pkg::CNT_W-1:0] cnt;
   logic [psc_pkg::CNT_W-1:0] next_cnt;
   psc_pkg::psc_req_s cur;
   logic drive;
   logic next_drive;
   psc_pkg::psc_ctl_s next_ctl;

   wire logic [psc_pkg::DATA_W-1:0] mask;

   wire logic cnt_done = (cnt <= psc_pkg::CNT_ONE);
   wire logic in_idle = (state == ST_IDLE);
   wire logic in_read = (state == ST_READ);
   wire logic read_end = in_read && cnt_done;
   // a request with no lane would select the memory for nothing, so it waits
   wire logic lane_any = (i_req.byte_en != '0);
   wire logic take = in_idle && i_req_valid && !i_power_down && lane_any;
   wire logic take_write = take && i_req.write;
   wire logic take_read = take && !i_req.write;
   wire logic go_sleep = in_idle && i_power_down;

   assign o_req_ready = take;
   assign o_busy = (state != ST_IDLE);

   always_comb begin
      next_state = state;
      next_cnt = cnt - psc_pkg::CNT_ONE;
      next_drive = drive;
      next_ctl = o_ctl;
      unique case (state)
         ST_WAKE: begin
            if (cnt_done) begin // R12
               next_state = ST_IDLE;
            end
         end

         ST_IDLE: begin
            next_ctl = psc_pkg::CTL_IDLE; // R05 R09
            next_drive = 1'b0;
            if (go_sleep) begin
               // contents are not kept; the user must reload after waking
               next_ctl.power_keep_select = 1'b0; // R11
               next_state = ST_SLEEP;
            end else if (take_write) begin
               // select and lanes first, strobe after the float time
               next_ctl.chip_select_n = 1'b0; // R05
               {next_ctl.upper_byte_enable_n, next_ctl.low_byte_enable_n} =
                  lanes_n(i_req.byte_en); // R13
               next_cnt = FL_N;
               next_state = ST_WSETUP;
            end else if (take_read) begin
               next_ctl.chip_select_n = 1'b0; // R10
               next_ctl.output_enable_n = 1'b0;
               {next_ctl.upper_byte_enable_n, next_ctl.low_byte_enable_n} =
                  lanes_n(i_req.byte_en);
               next_cnt = RC_N; // R14 R08
               next_state = ST_READ;
            end
         end

         ST_READ: begin
            if (cnt_done) begin
               // full select-high gap after every read: slower, but no burst starves refresh
               next_ctl = psc_pkg::CTL_IDLE;
               next_cnt = RC_N; // R09
               next_state = ST_WREC;
            end
         end

         ST_WSETUP: begin
            // output enable stays high, so the memory never drives here
            if (cnt_done) begin // R06
               next_ctl.write_strobe_n = 1'b0; // R01
               next_drive = 1'b1;
               next_cnt = WP_N; // R14
               next_state = ST_WPULSE;
            end
         end

         ST_WPULSE: begin
            if (cnt_done) begin
               next_ctl.write_strobe_n = 1'b1; // R02
               next_cnt = REC_N;
               next_state = ST_WREC;
            end
         end

         ST_WREC: begin
            // select rises a cycle after the strobe rises, so the strobe ends the write
            next_ctl.chip_select_n = 1'b1;
            next_ctl.upper_byte_enable_n = 1'b1;
            next_ctl.low_byte_enable_n = 1'b1;
            next_drive = 1'b0;
            if (cnt_done) begin
               next_state = ST_IDLE;
            end
         end

         ST_SLEEP: begin
            if (!i_power_down) begin
               next_ctl.power_keep_select = 1'b1; // R11
               next_cnt = EX_N; // R12
               next_state = ST_WAKE;
            end
         end

         default: begin
            // unknown code: back to standby and a full wake wait
            next_ctl = psc_pkg::CTL_IDLE;
            next_drive = 1'b0;
            next_cnt = EX_N;
            next_state = ST_WAKE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         state <= ST_WAKE;
         cnt <= EX_N;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // control pins leave flops only, so no decode glitch reaches the memory
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_ctl <= psc_pkg::CTL_IDLE;
         drive <= 1'b0;
      end else begin
         o_ctl <= next_ctl;
         drive <= next_drive;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         cur <= '0;
      end else if (take) begin
         cur <= i_req; // R07
      end
   end

   assign o_addr = cur.addr; // R07
   assign o_dq = cur.wdata;

   // one lane per byte enable; an unused lane is never driven
   for (genvar g = 0; g < psc_pkg::BE_W; g++) begin : g_lane
      assign mask[g*LANE_W +: LANE_W] = {LANE_W{cur.byte_en[g]}}; // R13
   end
   assign o_dq_oe = drive ? mask : '0; // R06 R13

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_rdata_valid <= 1'b0;
      end else begin
         o_rdata_valid <= read_end;
      end
   end

   // sampled in the last read cycle, where the access time has run out
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_rdata <= '0;
      end else if (read_end) begin
         o_rdata <= i_dq & mask; // R13
      end
   end
endmodule : psc_ctrl
`default_nettype wire

// ### tb/psc_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module psc_chk (
   input wire logic i_clock, i_nrst, i_req_valid, o_req_ready, // handshake
   input wire logic i_power_down, o_rdata_valid, o_busy, // status
   input var psc_pkg::psc_req_s i_req, // request
   input var psc_pkg::psc_ctl_s o_ctl, // memory controls
   input wire logic [15:0] o_rdata, i_dq, o_dq, o_dq_oe, // data
   input wire logic [19:0] o_addr // address pins
);
   wire logic cs_n = o_ctl.chip_select_n;
   wire logic we_n = o_ctl.write_strobe_n;
   wire logic oe_n = o_ctl.output_enable_n;
   wire logic keep = o_ctl.power_keep_select;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   property p_wr; $fell(we_n) |-> !cs_n && !(o_ctl.upper_byte_enable_n && o_ctl.low_byte_enable_n); endproperty
   a_wr: assert property (p_wr) else $error("strobe without select or lane");
   property p_drv; |o_dq_oe |-> oe_n && !cs_n; endproperty
   a_drv: assert property (p_drv) else $error("data driven while memory may drive");
   property p_adr; !cs_n && !we_n |-> $stable(o_addr); endproperty
   a_adr: assert property (p_adr) else $error("address moved in write");
   property p_idle; !o_busy |-> cs_n; endproperty
   a_idle: assert property (p_idle) else $error("selected while idle");
   property p_rd; o_rdata_valid |-> $past(!oe_n && we_n && keep && !cs_n); endproperty
   a_rd: assert property (p_rd) else $error("read data without read cycle");
   property p_pd; !keep |-> cs_n && !o_req_ready; endproperty
   a_pd: assert property (p_pd) else $error("access in power-down");
   property p_wake; $rose(keep) |-> o_busy [*8]; endproperty
   a_wake: assert property (p_wake) else $error("access too soon after wake");
   property p_rec; $rose(cs_n) && $past(!oe_n) |=> cs_n [*8]; endproperty
   a_rec: assert property (p_rec) else $error("select high too short after read");
   property p_wp; $fell(we_n) |=> !we_n [*6]; endproperty
   a_wp: assert property (p_wp) else $error("write pulse too short");
endmodule : psc_chk
bind psc_ctrl psc_chk i_chk (.*);
`default_nettype wire

// ### tb/psc_mem.sv
`timescale 1ns/1ps
`default_nettype none
module psc_mem (
   input var psc_pkg::psc_ctl_s i_ctl, // control pins
   input wire logic [19:0] i_addr, // address pins
   input wire logic [15:0] i_dq, // data pins in
   output logic [15:0] o_q, // read data
   output logic [15:0] o_q_oe // per bit drive
);
   logic [15:0] mem [16];
   wire logic [3:0] a = i_addr[3:0];
   wire logic rd = !i_ctl.chip_select_n && i_ctl.write_strobe_n && !i_ctl.output_enable_n
      && i_ctl.power_keep_select;
   assign o_q = mem[a];
   assign o_q_oe = {{8{rd && !i_ctl.upper_byte_enable_n}}, {8{rd && !i_ctl.low_byte_enable_n}}};
   // async part: data lands when the first of select or strobe rises
   always @(posedge i_ctl.write_strobe_n or posedge i_ctl.chip_select_n) begin
      if (!i_ctl.chip_select_n || !i_ctl.write_strobe_n) begin
         if (!i_ctl.upper_byte_enable_n) mem[a][15:8] = i_dq[15:8];
         if (!i_ctl.low_byte_enable_n) mem[a][7:0] = i_dq[7:0];
      end
   end
endmodule : psc_mem
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic i_clock = 0, i_nrst = 0, i_req_valid = 0, i_power_down = 0;
   psc_pkg::psc_req_s i_req = '0;
   logic o_req_ready, o_rdata_valid, o_busy;
   logic [15:0] o_rdata, o_dq, o_dq_oe, m_q, m_oe, i_dq;
   logic [19:0] o_addr;
   psc_pkg::psc_ctl_s o_ctl;
   int mismatches = 0, n_tests = 0;
   always #4 i_clock = ~i_clock;
   // released lanes toggle so stale data never passes
   assign i_dq = (o_dq & o_dq_oe) | (m_q & m_oe) | ((16'h5A5A ^ {16{i_clock}}) & ~(o_dq_oe | m_oe));
   psc_ctrl #(.EXIT_WAIT(20)) i_dut (.*);
   psc_mem i_mem (.i_ctl(o_ctl), .i_addr(o_addr), .i_dq(i_dq), .o_q(m_q), .o_q_oe(m_oe));
   task automatic chk(string n, logic [19:0] s, logic [19:0] e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic conclude();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic wait_on(ref logic s, input logic v);
      int k;
      for (k = 0; k < 99 && s !== v; k++) @(negedge i_clock);
      if (k == 99) begin
         mismatches++;
         conclude();
      end
   endtask : wait_on
   task automatic xfer(logic w, logic [19:0] a, logic [15:0] d, logic [1:0] be, logic [15:0] e);
      @(negedge i_clock);
      i_req = '{w, a, d, be};
      i_req_valid = 1;
      #1;
      wait_on(o_req_ready, 1);
      @(negedge i_clock);
      i_req_valid = 0;
      if (!w) begin
         wait_on(o_rdata_valid, 1);
         chk("rdata", o_rdata, e);
         chk("addr", o_addr, a);
      end
      wait_on(o_busy, 0);
   endtask : xfer
   task automatic t_wake();
      chk("busy", o_busy, 1);
      wait_on(o_busy, 0);
      $display("done wake");
   endtask : t_wake
   task automatic t_rw();
      xfer(1, 20'h00001, 16'h1234, 2'h3, 0);
      xfer(1, 20'h00002, 16'hC3E7, 2'h3, 0);
      xfer(0, 20'h00001, 0, 2'h3, 16'h1234);
      xfer(0, 20'h00002, 0, 2'h3, 16'hC3E7);
      $display("done rw");
   endtask : t_rw
   task automatic t_lanes();
      xfer(1, 20'h00003, 16'h1234, 2'h3, 0);
      xfer(1, 20'h00003, 16'hABCD, 2'h2, 0);
      xfer(0, 20'h00003, 0, 2'h3, 16'hAB34);
      xfer(0, 20'h00003, 0, 2'h1, 16'h0034);
      $display("done lanes");
   endtask : t_lanes
   task automatic t_refuse();
      @(negedge i_clock);
      i_req = '{1'b1, 20'h00004, 16'hFFFF, 2'h0};
      i_req_valid = 1;
      #1;
      chk("ready", o_req_ready, 0);
      repeat (3) @(negedge i_clock);
      chk("busy", o_busy, 0);
      chk("cs", o_ctl.chip_select_n, 1);
      i_req_valid = 0;
      $display("done refuse");
   endtask : t_refuse
   task automatic t_pdown();
      @(negedge i_clock);
      i_power_down = 1;
      repeat (3) @(negedge i_clock);
      chk("keep", o_ctl.power_keep_select, 0);
      i_power_down = 0;
      repeat (2) @(negedge i_clock);
      chk("busy", o_busy, 1);
      xfer(0, 20'h00003, 0, 2'h2, 16'hAB00);
      $display("done pdown");
   endtask : t_pdown
   initial begin
      repeat (8) @(negedge i_clock);
      chk("ctl", 20'(o_ctl), 20'(psc_pkg::CTL_IDLE));
      i_nrst = 1;
      t_wake();
      t_rw();
      t_lanes();
      t_refuse();
      t_pdown();
      conclude();
   end
endmodule : tb
`default_nettype wire
